// *** rtl/job_mailbox_pkg.sv ***
`default_nettype none
package job_mailbox_pkg;
  localparam int BUF_BYTES = 15;
  localparam int BUF_BITS = 8 * BUF_BYTES;
  localparam logic [3:0] STATUS_OFFSET = 4'hf;
  localparam int ST_DONE_OK = 0;
  localparam int ST_ACK = 1;
  localparam int ST_DATA_READY = 2;
  localparam int ST_UNUSED = 3;
  localparam int ST_ERR = 4;
  localparam int ST_UNCONF1 = 5;
  localparam int ST_UNCONF2 = 6;
  localparam int ST_EXPANSION = 7;
  localparam int ANNOUNCE_BIT = 7;
  localparam logic [7:0] JOB_REQUEST_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [7:0] ERRC_RST = 8'h00;
  localparam logic [7:0] JOB_READ_ERROR = 8'h01;
  localparam logic [7:0] JOB_READ_IRQ = 8'h31;
  localparam logic [7:0] JOB_RESET_COMM = 8'h40;
  localparam logic [2:0] GRP_CH1 = 3'h1;
  localparam logic [2:0] GRP_CH2 = 3'h2;
  localparam logic [3:0] SUB_POS_MULTI = 4'h0;
  localparam logic [3:0] SUB_INITIAL = 4'h1;
  localparam logic [3:0] SUB_TRACK_LAST = 4'h8;
  localparam logic [3:0] SUB_ZERO_OFFSET = 4'h9;
  localparam logic [3:0] SUB_CONTROL = 4'ha;
  localparam logic [3:0] SUB_READ_ACTUAL = 4'hb;
  localparam logic [3:0] SUB_CLOSE = 4'hd;
  localparam logic [7:0] ERRC_UNDEFINED = 8'h01;
  localparam logic [7:0] ERRC_UNCONFIGURED = 8'h02;

  typedef enum logic [1:0] {
    MODE_DECODE,
    MODE_COUNT,
    MODE_POSITION,
    MODE_EXPANSION
  } mode_e;

  typedef enum logic [3:0] {
    JOB_BAD,
    JOB_NOCHAN,
    JOB_ERRREAD,
    JOB_IRQREAD,
    JOB_RESET,
    JOB_LOAD,
    JOB_ANNOUNCE,
    JOB_STATREAD,
    JOB_CLOSE
  } job_e;

  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic configured;
    mode_e mode;
  } chan_info_s;
endpackage
`default_nettype wire

// *** rtl/job_mailbox_host_port.sv ***
// Operation
// - Decode sixteen host byte offsets 0 to 15 above the module base.
// - Offsets 0 to 14 are a shared buffer, host reads and writes.
// - Offset 15 reads status and writes the job request register.
// - Read job: device fills buffer, then host reads it out.
// - One interchange per processing cycle; next cycle refused after a load.
// - Status bits 5 and 6 show channel 1 and 2 unconfigured.
// - Bit 4 flags pending error; job 01h reads code and clears it.
// - Bit 0 shows last cycle done without error, also after config.
// - Bit 1 acknowledges job recognition, meaningful after reset.
// - Bit 2 shows read data placed or written data fetched.
// - Bit 7 shows both channels in expansion mode; bit 3 unused.
// - Job 40h resets the communication state before new cycles.
// - Job 31h places both channels' interrupt request bytes in buffer.
// - Track limit codes per mode; counting uses 11h/21h initial count.
// - Codes 19h/29h zero offset, 1Ah/2Ah control bits.
// - Codes 1Bh/2Bh return actual value and status area.
// - Codes 1Dh/2Dh close a write interchange in decode and count.
// - Positioning: 10h/20h, 11h/21h positions 1-254, 18h/28h position 0.
// - Positioning: 40h resets or terminates the interchange.
`default_nettype none
module job_mailbox_host_port
  import job_mailbox_pkg::*;
#(
  parameter int CYCLE_CLKS = 16
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire host_req_s HOST_REQ,
  output logic [7:0] HOST_RDATA,
  input wire chan_info_s CH1_INFO,
  input wire chan_info_s CH2_INFO,
  input wire logic [15:0] CH1_IRQ_BYTES,
  input wire logic [15:0] CH2_IRQ_BYTES,
  input wire logic [BUF_BITS-1:0] CH1_AREA,
  input wire logic [BUF_BITS-1:0] CH2_AREA,
  output logic ENGINE_STB,
  output logic [7:0] ENGINE_CODE,
  output logic [BUF_BITS-1:0] WR_IMAGE
);

  localparam int CW = (CYCLE_CLKS > 2) ? $clog2(CYCLE_CLKS) : 1;

  generate
    if (CYCLE_CLKS < 2) begin : g_bad_cycle
      $error("CYCLE_CLKS must be at least 2");
    end
  endgenerate

  // Load and close codes that the channel's mode accepts
  function automatic logic [1:0] mode_codes(input logic [3:0] sub,
                                            input mode_e mode);
    logic ld;
    logic cl;
    ld = 1'b0;
    cl = 1'b0;
    unique case (mode)
      MODE_DECODE: begin
        ld = (sub >= SUB_INITIAL && sub <= SUB_TRACK_LAST)
          || sub == SUB_ZERO_OFFSET
          || sub == SUB_CONTROL;
        cl = (sub == SUB_CLOSE);
      end
      MODE_COUNT: begin
        ld = (sub == SUB_INITIAL) || (sub == SUB_CONTROL);
        cl = (sub == SUB_CLOSE);
      end
      MODE_POSITION: begin
        ld = (sub == SUB_POS_MULTI) || (sub == SUB_INITIAL)
          || (sub == SUB_TRACK_LAST) || (sub == SUB_ZERO_OFFSET)
          || (sub == SUB_CONTROL);
        cl = 1'b0;
      end
      MODE_EXPANSION: begin
        ld = 1'b0;
        cl = 1'b0;
      end
    endcase
    return {cl, ld};
  endfunction

  function automatic job_e classify(input logic [7:0] code,
                                    input chan_info_s ci);
    logic [2:0] grp;
    logic [1:0] mc;
    job_e j;
    grp = code[6:4];
    mc = mode_codes(code[3:0], ci.mode);
    if (code == JOB_READ_ERROR) begin
      j = JOB_ERRREAD;
    end else if (code == JOB_READ_IRQ) begin
      j = JOB_IRQREAD;
    end else if (code == JOB_RESET_COMM) begin
      j = JOB_RESET;
    end else if (grp != GRP_CH1 && grp != GRP_CH2) begin
      j = JOB_BAD;
    end else if (!ci.configured) begin
      j = JOB_NOCHAN;
    end else if (mc[0]) begin
      j = code[ANNOUNCE_BIT] ? JOB_ANNOUNCE : JOB_LOAD;
    end else if (code[ANNOUNCE_BIT]) begin
      j = JOB_BAD;
    end else if (code[3:0] == SUB_READ_ACTUAL
                 && ci.mode != MODE_EXPANSION) begin
      j = JOB_STATREAD;
    end else if (mc[1]) begin
      j = JOB_CLOSE;
    end else begin
      j = JOB_BAD;
    end
    return j;
  endfunction

  logic [7:0] buf_reg [BUF_BYTES];
  logic [7:0] job_reg;
  logic [7:0] errc_reg;
  logic [CW-1:0] cyc_reg;
  logic pend_reg;
  logic ack_reg;
  logic done_reg;
  logic ready_reg;
  logic err_reg;
  logic refuse_reg;
  logic cfg1_reg;
  logic cfg2_reg;

  wire logic host_wr;
  wire logic host_rd;
  wire logic at_status;
  wire logic job_wr;
  wire logic buf_wr;
  wire logic tick;
  wire logic serve;
  wire logic fill;
  wire logic to_engine;
  wire logic completes;
  wire logic gives_data;
  wire logic fails;
  wire logic cfg_rise;
  wire logic expansion;
  wire logic ch2_sel;
  wire chan_info_s cur_info;
  wire job_e job_class;
  wire logic [3:0] byte_sel;
  wire logic [7:0] buf_rd;
  wire logic [7:0] status;
  wire logic [7:0] errc_next;
  wire logic [BUF_BITS-1:0] fill_image;

  // Host bus decode
  assign host_wr = HOST_REQ.cs & HOST_REQ.wr;
  assign host_rd = HOST_REQ.cs & HOST_REQ.rd;
  assign at_status = (HOST_REQ.addr == STATUS_OFFSET);
  assign job_wr = host_wr & at_status;
  assign buf_wr = host_wr & ~at_status;
  assign byte_sel = at_status ? 4'h0 : HOST_REQ.addr;
  assign buf_rd = buf_reg[byte_sel];

  // Job decode on the latched request
  assign ch2_sel = (job_reg[6:4] == GRP_CH2);
  assign cur_info = ch2_sel ? CH2_INFO : CH1_INFO;
  assign job_class = classify(job_reg, cur_info);

  // Internal processing cycle
  assign tick = (cyc_reg == CW'(CYCLE_CLKS - 1));
  // A job written in the same cycle defers service to keep it intact
  assign serve = tick & pend_reg & ~refuse_reg & ~job_wr;

  assign fill = serve & (job_class == JOB_ERRREAD
    || job_class == JOB_IRQREAD
    || job_class == JOB_STATREAD);
  assign to_engine = serve & (job_class == JOB_LOAD
    || job_class == JOB_CLOSE
    || job_class == JOB_RESET);
  assign gives_data = fill | (serve & job_class == JOB_LOAD);
  assign completes = gives_data | (serve & (job_class == JOB_CLOSE
    || job_class == JOB_RESET));
  assign fails = serve & (job_class == JOB_BAD
    || job_class == JOB_NOCHAN);
  assign errc_next = (job_class == JOB_NOCHAN) ? ERRC_UNCONFIGURED
    : ERRC_UNDEFINED;

  assign fill_image =
    (job_class == JOB_ERRREAD) ? {(BUF_BITS - 8)'(0), errc_reg}
    : (job_class == JOB_IRQREAD)
      ? {(BUF_BITS - 32)'(0), CH2_IRQ_BYTES, CH1_IRQ_BYTES}
      : ch2_sel ? CH2_AREA : CH1_AREA;

  assign cfg_rise = (CH1_INFO.configured & ~cfg1_reg)
    | (CH2_INFO.configured & ~cfg2_reg);
  assign expansion = CH1_INFO.configured & CH2_INFO.configured
    & (CH1_INFO.mode == MODE_EXPANSION)
    & (CH2_INFO.mode == MODE_EXPANSION);

  assign status[ST_DONE_OK] = done_reg;
  assign status[ST_ACK] = ack_reg;
  assign status[ST_DATA_READY] = ready_reg;
  assign status[ST_UNUSED] = 1'b0;
  assign status[ST_ERR] = err_reg;
  assign status[ST_UNCONF1] = ~CH1_INFO.configured;
  assign status[ST_UNCONF2] = ~CH2_INFO.configured;
  assign status[ST_EXPANSION] = expansion;

  always_ff @(posedge REF_CLK) begin
    if (RST || tick) begin
      cyc_reg <= '0;
    end else begin
      cyc_reg <= cyc_reg + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      job_reg <= JOB_REQUEST_RST;
      pend_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (job_wr) begin
      job_reg <= HOST_REQ.wdata;
      pend_reg <= 1'b1;
      ack_reg <= 1'b1;
    end else if (serve) begin
      pend_reg <= 1'b0;
    end
  end

  // A fresh job clears done and ready; a completing job sets done later, and a job that gives data also sets ready
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      done_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else if (job_wr) begin
      done_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      done_reg <= done_reg | completes | cfg_rise;
      ready_reg <= gives_data
        | (ready_reg & ~(serve & job_class == JOB_RESET));
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      err_reg <= 1'b0;
      errc_reg <= ERRC_RST;
    end else if (fails) begin
      err_reg <= 1'b1;
      errc_reg <= errc_next;
    end else if (serve && job_class == JOB_ERRREAD) begin
      err_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      refuse_reg <= 1'b0;
    end else if (serve && job_class == JOB_LOAD) begin
      refuse_reg <= 1'b1;
    end else if (tick) begin
      refuse_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cfg1_reg <= 1'b0;
      cfg2_reg <= 1'b0;
    end else begin
      cfg1_reg <= CH1_INFO.configured;
      cfg2_reg <= CH2_INFO.configured;
    end
  end

  // Engine sees loads, closes and resets as a one-cycle strobe
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ENGINE_STB <= 1'b0;
      ENGINE_CODE <= JOB_REQUEST_RST;
    end else begin
      ENGINE_STB <= to_engine;
      ENGINE_CODE <= to_engine ? job_reg : ENGINE_CODE;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      HOST_RDATA <= BUF_RST;
    end else if (host_rd) begin
      HOST_RDATA <= at_status ? status : buf_rd;
    end
  end

  // Device fill wins over a host write to the same byte
  generate
    for (genvar i = 0; i < BUF_BYTES; i++) begin : g_buf
      always_ff @(posedge REF_CLK) begin
        if (RST) begin
          buf_reg[i] <= BUF_RST;
        end else if (fill) begin
          buf_reg[i] <= fill_image[8*i +: 8];
        end else if (buf_wr && HOST_REQ.addr == 4'(i)) begin
          buf_reg[i] <= HOST_REQ.wdata;
        end
      end
      assign WR_IMAGE[8*i +: 8] = buf_reg[i];
    end
  endgenerate

endmodule // job_mailbox_host_port
`default_nettype wire

// *** dv/job_mailbox_host_port_props.sv ***
`default_nettype none
module job_mailbox_host_port_props
  import job_mailbox_pkg::*;
#(
  parameter int CYCLE_CLKS = 16
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire host_req_s HOST_REQ,
  input wire logic [7:0] HOST_RDATA,
  input wire chan_info_s CH1_INFO,
  input wire chan_info_s CH2_INFO,
  input wire logic [15:0] CH1_IRQ_BYTES,
  input wire logic [15:0] CH2_IRQ_BYTES,
  input wire logic [BUF_BITS-1:0] CH1_AREA,
  input wire logic [BUF_BITS-1:0] CH2_AREA,
  input wire logic ENGINE_STB,
  input wire logic [7:0] ENGINE_CODE,
  input wire logic [BUF_BITS-1:0] WR_IMAGE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  int cnt_reg;
  logic [7:0] byte_reg;
  logic seen_reg;
  wire logic at_st = HOST_REQ.cs && HOST_REQ.addr == STATUS_OFFSET;
  wire logic rd_st = at_st && HOST_REQ.rd;
  wire logic rd_buf = HOST_REQ.cs && HOST_REQ.rd && !at_st;
  wire logic job_wr = at_st && HOST_REQ.wr;
  wire logic tick = cnt_reg == CYCLE_CLKS - 1;
  wire logic cfg_same = CH1_INFO == CH2_INFO;
  // Mirror of the service tick and of the first job since reset
  always_ff @(posedge REF_CLK) begin
    cnt_reg <= (RST || tick) ? 0 : cnt_reg + 1;
    seen_reg <= !RST && (seen_reg || job_wr);
    byte_reg <= WR_IMAGE[8*HOST_REQ.addr +: 8];
  end
  rst_clear_a: assert property (disable iff (1'b0) RST |=>
    HOST_RDATA == 8'h00 && !ENGINE_STB && WR_IMAGE == '0)
    else $error("outputs not cleared by reset");
  buf_read_a: assert property (rd_buf |=> HOST_RDATA == byte_reg)
    else $error("buffer read returned wrong byte");
  unconf_bits_a: assert property (
    rd_st && $stable(CH1_INFO) && $stable(CH2_INFO) |=>
    HOST_RDATA[ST_UNCONF1] == !$past(CH1_INFO.configured) &&
    HOST_RDATA[ST_UNCONF2] == !$past(CH2_INFO.configured))
    else $error("unconfigured bits wrong");
  expansion_bit_a: assert property (
    rd_st && $stable(CH1_INFO) && $stable(CH2_INFO) |=>
    !HOST_RDATA[ST_UNUSED] && HOST_RDATA[ST_EXPANSION] == $past(cfg_same
    && CH1_INFO.configured && CH1_INFO.mode == MODE_EXPANSION))
    else $error("expansion or unused bit wrong");
  ack_seen_a: assert property (
    rd_st |=> HOST_RDATA[ST_ACK] == $past(seen_reg))
    else $error("acknowledge bit wrong");
  job_clear_a: assert property (
    job_wr ##1 (!tick && !job_wr) ##1 rd_st |=>
    !HOST_RDATA[ST_DONE_OK] && !HOST_RDATA[ST_DATA_READY])
    else $error("done or ready not cleared by job");
  stb_tick_a: assert property (ENGINE_STB |-> $past(tick))
    else $error("strobe outside a service tick");
  stb_code_a: assert property (ENGINE_STB |->
    ENGINE_CODE == JOB_RESET_COMM || (ENGINE_CODE[3:0] != SUB_READ_ACTUAL
    && ENGINE_CODE[7:4] inside {4'h1, 4'h2}))
    else $error("strobe with undefined code");
  cover property (ENGINE_STB && ENGINE_CODE == JOB_RESET_COMM);
  cover property (rd_st ##1 HOST_RDATA[ST_ERR]);
  cover property (job_wr ##1 (!tick && !job_wr) ##1 rd_st);
endmodule // job_mailbox_host_port_props
bind job_mailbox_host_port job_mailbox_host_port_props #(
  .CYCLE_CLKS(CYCLE_CLKS)
) props (.REF_CLK(REF_CLK), .RST(RST), .HOST_REQ(HOST_REQ),
  .HOST_RDATA(HOST_RDATA), .CH1_INFO(CH1_INFO), .CH2_INFO(CH2_INFO),
  .CH1_IRQ_BYTES(CH1_IRQ_BYTES), .CH2_IRQ_BYTES(CH2_IRQ_BYTES),
  .CH1_AREA(CH1_AREA), .CH2_AREA(CH2_AREA), .ENGINE_STB(ENGINE_STB),
  .ENGINE_CODE(ENGINE_CODE), .WR_IMAGE(WR_IMAGE));
`default_nettype wire

// *** dv/host_cpu.sv ***
`default_nettype none
module host_cpu
  import job_mailbox_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic [7:0] HOST_RDATA,
  output host_req_s HOST_REQ
);
  timeunit 1ns;
  timeprecision 1ps;
  initial HOST_REQ = '0;
  // Released bus shows inverted lines so stale values never match
  task automatic access(input logic w, input logic [3:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(posedge REF_CLK);
    HOST_REQ <= '{1'b1, w, !w, a, d};
    @(posedge REF_CLK);
    HOST_REQ <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
    #1 q = HOST_RDATA;
  endtask
  task automatic status(output logic [7:0] s);
    access(1'b0, STATUS_OFFSET, 8'h00, s);
  endtask
  task automatic job(input logic [7:0] c);
    logic [7:0] q;
    access(1'b1, STATUS_OFFSET, c, q);
  endtask
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    status(q);
    access(1'b1, a, d, q);
  endtask
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    status(d);
    access(1'b0, a, 8'h00, d);
  endtask
endmodule // host_cpu
`default_nettype wire

// *** dv/job_mailbox_host_port_bench.sv ***
`default_nettype none
module job_mailbox_host_port_bench
  import job_mailbox_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 4;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  host_req_s HOST_REQ;
  logic [7:0] HOST_RDATA;
  chan_info_s CH1_INFO = '{1'b0, MODE_DECODE};
  chan_info_s CH2_INFO = '{1'b0, MODE_COUNT};
  logic [15:0] CH1_IRQ_BYTES = 16'hb1a1;
  logic [15:0] CH2_IRQ_BYTES = 16'hd2c2;
  logic [BUF_BITS-1:0] CH1_AREA;
  logic [BUF_BITS-1:0] CH2_AREA;
  logic ENGINE_STB;
  logic [7:0] ENGINE_CODE;
  logic [BUF_BITS-1:0] WR_IMAGE;
  int fails = 0;
  int checks = 0;
  always #2 REF_CLK = ~REF_CLK;
  job_mailbox_host_port #(.CYCLE_CLKS(CYC)) dut (.REF_CLK(REF_CLK),
    .RST(RST), .HOST_REQ(HOST_REQ), .HOST_RDATA(HOST_RDATA),
    .CH1_INFO(CH1_INFO), .CH2_INFO(CH2_INFO),
    .CH1_IRQ_BYTES(CH1_IRQ_BYTES), .CH2_IRQ_BYTES(CH2_IRQ_BYTES),
    .CH1_AREA(CH1_AREA), .CH2_AREA(CH2_AREA), .ENGINE_STB(ENGINE_STB),
    .ENGINE_CODE(ENGINE_CODE), .WR_IMAGE(WR_IMAGE));
  host_cpu hm (.REF_CLK(REF_CLK), .HOST_RDATA(HOST_RDATA),
    .HOST_REQ(HOST_REQ));
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic poll(input logic [7:0] m, output logic [7:0] s);
    s = '0;
    for (int i = 0; i < 40 && (s & m) == 0; i++) hm.status(s);
  endtask
  task automatic stb_wait(output int n);
    n = 0;
    do begin
      @(posedge REF_CLK);
      #1 n++;
    end while (ENGINE_STB !== 1'b1 && n < 40);
  endtask
  task automatic t_cfg(input mode_e m1, input mode_e m2,
      input logic [7:0] e);
    logic [7:0] s;
    @(posedge REF_CLK);
    CH1_INFO <= '{1'b1, m1};
    CH2_INFO <= '{1'b1, m2};
    repeat (3) @(posedge REF_CLK);
    hm.status(s);
    chk(s, e);
  endtask
  task automatic t_buf();
    logic [7:0] d;
    for (int i = 0; i < BUF_BYTES; i++) hm.put(4'(i), 8'ha0 + 8'(i));
    for (int i = 0; i < BUF_BYTES; i++) begin
      hm.get(4'(i), d);
      chk(d, 8'ha0 + 8'(i));
      chk(WR_IMAGE[8*i +: 8], 8'ha0 + 8'(i));
    end
  endtask
  task automatic rdjob(input logic [7:0] c, input logic [BUF_BITS-1:0] e);
    logic [7:0] s;
    logic [7:0] d;
    hm.job(c);
    poll(8'h04, s);
    chk(s, 8'h07);
    for (int i = 0; i < BUF_BYTES; i++) begin
      hm.get(4'(i), d);
      chk(d, e[8*i +: 8]);
    end
  endtask
  task automatic t_abort();
    logic [7:0] s;
    int n;
    hm.job(JOB_RESET_COMM);
    stb_wait(n);
    chk(ENGINE_CODE, JOB_RESET_COMM);
    hm.status(s);
    chk(s, 8'h03);
  endtask
  task automatic t_wr();
    logic [7:0] s;
    int n;
    hm.job(8'h91);
    repeat (2 * CYC) @(posedge REF_CLK);
    hm.status(s);
    chk(s, 8'h02);
    for (int i = 0; i < BUF_BYTES; i++) hm.put(4'(i), 8'(i));
    hm.job(8'h11);
    stb_wait(n);
    chk(ENGINE_CODE, 8'h11);
    hm.job(8'h1d);
    stb_wait(n);
    chk({7'h00, n > CYC}, 8'h01);
    chk(ENGINE_CODE, 8'h1d);
    hm.status(s);
    chk(s, 8'h03);
  endtask
  task automatic t_err();
    logic [BUF_BITS-1:0] img;
    logic [7:0] s;
    img = WR_IMAGE;
    hm.job(8'h55);
    poll(8'h10, s);
    chk(s, 8'h12);
    chk({7'h00, WR_IMAGE === img}, 8'h01);
  endtask
  task automatic t_idle();
    logic [7:0] s;
    hm.status(s);
    chk(s, 8'h60);
  endtask
  task automatic t_pos();
    int n;
    t_cfg(MODE_POSITION, MODE_COUNT, 8'h07);
    hm.job(8'h10);
    stb_wait(n);
    chk(ENGINE_CODE, 8'h10);
  endtask
  // Channel 2 drops out of configuration; its jobs must be refused
  task automatic t_nochan();
    logic [7:0] s;
    logic [7:0] d;
    @(posedge REF_CLK);
    CH2_INFO <= '{1'b0, MODE_COUNT};
    hm.job(8'h2b);
    poll(8'h10, s);
    chk(s, 8'h52);
    hm.job(JOB_READ_ERROR);
    poll(8'h04, s);
    chk(s, 8'h47);
    hm.get(4'h0, d);
    chk(d, ERRC_UNCONFIGURED);
  endtask
  initial begin
    #40000;
    fails++;
    conclude();
  end
  initial begin
    for (int k = 0; k < BUF_BYTES; k++) begin
      CH1_AREA[8*k +: 8] = 8'h30 + 8'(k);
      CH2_AREA[8*k +: 8] = 8'h50 + 8'(k);
    end
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    t_idle();
    t_cfg(MODE_EXPANSION, MODE_EXPANSION, 8'h81);
    t_cfg(MODE_DECODE, MODE_COUNT, 8'h01);
    t_buf();
    rdjob(8'h1b, CH1_AREA);
    rdjob(8'h2b, CH2_AREA);
    rdjob(JOB_READ_IRQ, BUF_BITS'({CH2_IRQ_BYTES, CH1_IRQ_BYTES}));
    t_abort();
    t_wr();
    t_err();
    rdjob(JOB_READ_ERROR, BUF_BITS'(ERRC_UNDEFINED));
    t_pos();
    t_nochan();
    conclude();
  end
endmodule // job_mailbox_host_port_bench
`default_nettype wire
